/* ubg_pkg.sv */
// Constants, register map and state types for the baud generator and
// shift-register serial port. Assumes one oscillator clock, mclk, that
// also serves as the phase clock of the machine cycle.
// Summary of operation
// - Timer 1 source: bit rate is timer 1 overflows doubled by flag, over 32.
// - Timer 1 auto-reload: rate = scale/32 * fosc/(12*(256 - reload byte)).
// - Timer 1 works as source as timer or counter, in all three modes.
// - Transmit or receive clock select puts timer 2 in baud generator mode.
// - Timer 2 control selects port one clocks, power control port two.
// - Baud mode: each high byte overflow reloads both count bytes.
// - Timer 2 source: bit rate equals timer 2 overflow rate over 16.
// - Baud timer mode: timer 2 steps each state time, fosc/(32*(65536-rl)).
// - Baud mode overflow never sets the overflow flag or interrupts.
// - Baud mode trigger fall sets trigger flag without any reload.
// - Mode 0 moves 8 bits LSB first with shift clock at fosc/12.
// - Mode 0 buffer write loads marker 1, sending starts a cycle later.
// - Sending: clock low S3-S5, high S6-S2, shift right at S6P2.
// - Zero fill; marker above MSB ends it; done flag at S1P1 cycle 10.
// - Receive starts on enable with done clear, loads 11111110 at S6P2.
// - Receiving: clock edges S3P1, S6P1, shift left pin sampled at S5P2.
// - Marker 0 at left: last shift, load buffer, set done at S1P1.
// - Mode bits 00 select shift mode, other codes the asynchronous modes.
package ubg_pkg;

  // Register offsets on the plain register port.
  localparam logic [3:0] ADR_SER_CTRL = 4'h0;
  localparam logic [3:0] ADR_SER_BUF = 4'h1;
  localparam logic [3:0] ADR_TMODE = 4'h2;
  localparam logic [3:0] ADR_T1_LOW = 4'h3;
  localparam logic [3:0] ADR_T1_RELOAD = 4'h4;
  localparam logic [3:0] ADR_T1_CTRL = 4'h5;
  localparam logic [3:0] ADR_T2_CTRL = 4'h6;
  localparam logic [3:0] ADR_T2_LOW = 4'h7;
  localparam logic [3:0] ADR_T2_HIGH = 4'h8;
  localparam logic [3:0] ADR_RL_LOW = 4'h9;
  localparam logic [3:0] ADR_RL_HIGH = 4'hA;
  localparam logic [3:0] ADR_PWR_CTRL = 4'hB;

  // Field positions of the serial control register.
  localparam int SC_MODE_LOW = 7;
  localparam int SC_MODE_HIGH = 6;
  localparam int SC_RX_EN = 4;
  localparam int SC_TX_DONE = 1;
  localparam int SC_RX_DONE = 0;

  // Field positions of timer 2 control, power control, timer 1 control.
  localparam int T2C_OVF = 7;
  localparam int T2C_EXT_FLAG = 6;
  localparam int T2C_RX_CLK = 5;
  localparam int T2C_TX_CLK = 4;
  localparam int T2C_EXT_EN = 3;
  localparam int T2C_RUN = 2;
  localparam int T2C_CNT_SEL = 1;
  localparam int PC_DOUBLE = 7;
  localparam int PC_RX_CLK2 = 5;
  localparam int PC_TX_CLK2 = 4;
  localparam int T1C_RUN = 0;
  localparam int T1C_OVF = 1;
  localparam int TM_T1_CNT_SEL = 6;
  localparam int TM_T1_MODE_HI = 5;
  localparam int TM_T1_MODE_LO = 4;

  // Reset value of every register and of the read data.
  localparam logic [7:0] RST_BYTE = 8'h00;
  localparam logic [15:0] RST_WORD = 16'h0000;

  // Timer 1 running modes.
  localparam logic [1:0] T1M_13BIT = 2'h0;
  localparam logic [1:0] T1M_16BIT = 2'h1;
  localparam logic [1:0] T1M_RELOAD = 2'h2;

  // Phase numbers within a machine cycle, S1P1 is phase 0.
  localparam logic [3:0] PH_S1P1 = 4'h0;
  localparam logic [3:0] PH_S3P1 = 4'h4;
  localparam logic [3:0] PH_S5P2 = 4'h9;
  localparam logic [3:0] PH_S6P2 = 4'hB;

  // Shift register markers and baud divider end counts.
  localparam logic TX_MARK = 1'b1;
  localparam logic [7:0] TX_LAST_PATTERN = 8'h01;
  localparam logic [7:0] RX_LOAD_PATTERN = 8'hFE;
  localparam logic [4:0] T1_DIV_NORMAL = 5'h1F;
  localparam logic [3:0] T1_DIV_DOUBLE = 4'hF;
  localparam logic [3:0] T2_DIV_END = 4'hF;
  localparam logic [4:0] DIV_ZERO = 5'h00;

  typedef enum logic [1:0] {
    UBG_TX_IDLE = 2'b00,
    UBG_TX_ARM = 2'b01,
    UBG_TX_SEND = 2'b11,
    UBG_TX_LAST = 2'b10
  } ubg_tx_st_t;

  typedef enum logic [1:0] {
    UBG_RX_IDLE = 2'b00,
    UBG_RX_ARM = 2'b01,
    UBG_RX_ACT = 2'b11,
    UBG_RX_LAST = 2'b10
  } ubg_rx_st_t;

endpackage

/* ubg_timer2.sv */
// Timer 2 counter with reload pair, in baud generator or plain reload use.
// Assumes the top supplies phase strobes and one-cycle edge pulses.
module ubg_timer2
  import ubg_pkg::*;
(
  input wire logic mclk,
  input wire logic rstn,
  input wire logic state_tick,
  input wire logic mc_tick,
  input wire logic run,
  input wire logic counter_sel,
  input wire logic baud_mode,
  input wire logic ext_enable,
  input wire logic count_fall,
  input wire logic ext_fall,
  input wire logic wr_low,
  input wire logic wr_high,
  input wire logic wr_rl_low,
  input wire logic wr_rl_high,
  input wire logic [7:0] wdata,
  output logic [15:0] count_q,
  output logic [15:0] reload_q,
  output logic ovf_q,
  output logic tf_set_q,
  output logic exf_set_q
);

  logic [15:0] count_d;
  logic [15:0] reload_d;
  logic ovf_d;
  logic tf_set_d;
  logic exf_set_d;
  logic step;

  // Counting, reload and flag events for one clock.
  always_comb begin
    count_d = count_q;
    reload_d = reload_q;
    ovf_d = 1'b0;
    tf_set_d = 1'b0;
    exf_set_d = 1'b0;
    if (counter_sel) begin
      step = run & count_fall;
    end else if (baud_mode) begin
      step = run & state_tick;
    end else begin
      step = run & mc_tick;
    end
    if (step) begin
      if (count_q == 16'hFFFF) begin
        count_d = reload_q;
        ovf_d = baud_mode;
        tf_set_d = ~baud_mode;
      end else begin
        count_d = count_q + 16'h0001;
      end
    end
    if (ext_enable && ext_fall) begin
      exf_set_d = 1'b1;
      if (!baud_mode) begin
        count_d = reload_q;
      end
    end
    if (wr_low) begin
      count_d[7:0] = wdata;
    end
    if (wr_high) begin
      count_d[15:8] = wdata;
    end
    if (wr_rl_low) begin
      reload_d[7:0] = wdata;
    end
    if (wr_rl_high) begin
      reload_d[15:8] = wdata;
    end
  end

  // Timer 2 state.
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      count_q <= RST_WORD;
      reload_q <= RST_WORD;
      ovf_q <= 1'b0;
      tf_set_q <= 1'b0;
      exf_set_q <= 1'b0;
    end else begin
      count_q <= count_d;
      reload_q <= reload_d;
      ovf_q <= ovf_d;
      tf_set_q <= tf_set_d;
      exf_set_q <= exf_set_d;
    end
  end

endmodule

/* ubg_top.sv */
// Baud rate generation from timers 1 and 2 and the mode 0 shift port.
// Assumes a register master on the plain port and a shift device on the
// data and clock pins, all synchronous to mclk.
module ubg_top
  import ubg_pkg::*;
(
  input wire logic mclk,
  input wire logic rstn,
  input wire logic [3:0] addr,
  input wire logic [7:0] wdata,
  input wire logic wr,
  input wire logic rd,
  output logic [7:0] rdata_q,
  input wire logic data_i,
  output logic data_o_q,
  output logic data_oe_n_q,
  output logic shift_clk_q,
  input wire logic t1_count_pin,
  input wire logic t2_count_pin,
  input wire logic ext_trigger_pin,
  output logic p1_tx_bit_tick_q,
  output logic p1_rx_bit_tick_q,
  output logic p2_tx_bit_tick_q,
  output logic p2_rx_bit_tick_q,
  output logic tx_done_flag_q,
  output logic rx_done_flag_q,
  output logic t1_overflow_q,
  output logic t2_overflow_flag_q,
  output logic ext_trigger_flag_q
);

  // Reverses a byte, used for the received word and nothing else yet.
  function automatic logic [7:0] ubg_rev8(input logic [7:0] v);
    logic [7:0] r;
    r = 8'h00;
    for (int i = 0; i < 8; i++) begin
      r[i] = v[7 - i];
    end
    return r;
  endfunction

  logic [3:0] phase_q, phase_d;
  logic mc_tick, state_tick;
  logic [7:0] serial_control_reg_q, serial_control_reg_d;
  logic [7:0] serial_buffer_q, serial_buffer_d;
  logic [7:0] timer_mode_reg_q, timer_mode_reg_d;
  logic [7:0] t1_low_q, t1_low_d;
  logic [7:0] t1_reload_byte_q, t1_reload_byte_d;
  logic [1:0] t1_ctrl_q, t1_ctrl_d;
  logic [7:0] second_timer_control_reg_q, second_timer_control_reg_d;
  logic [7:0] power_control_reg_q, power_control_reg_d;
  logic [7:0] rdata_d;
  logic t1_pin_prev_q, t2_pin_prev_q, ext_pin_prev_q;
  logic t1_fall, t2_fall, ext_fall;
  logic t1_ovf;
  logic [4:0] t1_div_q, t1_div_d;
  logic [3:0] t2_div_q, t2_div_d;
  logic t1_bit, t2_bit;
  logic [15:0] t2_count, t2_reload;
  logic t2_ovf, t2_tf_set, t2_exf_set;
  logic t2_baud_mode, mode_zero, mode_variable;
  logic wr_ctrl, wr_buf;
  ubg_tx_st_t tx_st_q, tx_st_d;
  ubg_rx_st_t rx_st_q, rx_st_d;
  logic [8:0] tx_sh_q, tx_sh_d;
  logic [7:0] rx_sh_q, rx_sh_d;
  logic rx_sample_q, rx_sample_d;
  logic tx_done_set, rx_done_set;
  logic [7:0] rx_word;
  logic clk_active;

  // Machine cycle of twelve phases, state time every second phase.
  assign phase_d = (phase_q == PH_S6P2) ? PH_S1P1 : phase_q + 4'h1;
  assign mc_tick = (phase_q == PH_S6P2);
  assign state_tick = phase_q[0];

  // Pin edges are taken once per machine cycle.
  assign t1_fall = mc_tick & t1_pin_prev_q & ~t1_count_pin;
  assign t2_fall = mc_tick & t2_pin_prev_q & ~t2_count_pin;
  assign ext_fall = mc_tick & ext_pin_prev_q & ~ext_trigger_pin;

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      phase_q <= PH_S1P1;
      t1_pin_prev_q <= 1'b1;
      t2_pin_prev_q <= 1'b1;
      ext_pin_prev_q <= 1'b1;
    end else begin
      phase_q <= phase_d;
      if (mc_tick) begin
        t1_pin_prev_q <= t1_count_pin;
        t2_pin_prev_q <= t2_count_pin;
        ext_pin_prev_q <= ext_trigger_pin;
      end
    end
  end

  // Mode decode and clock source selection per port.
  assign mode_zero = ~serial_control_reg_q[SC_MODE_LOW] &
                     ~serial_control_reg_q[SC_MODE_HIGH];
  assign mode_variable = serial_control_reg_q[SC_MODE_HIGH];
  assign t2_baud_mode = second_timer_control_reg_q[T2C_RX_CLK] |
                        second_timer_control_reg_q[T2C_TX_CLK] |
                        power_control_reg_q[PC_RX_CLK2] |
                        power_control_reg_q[PC_TX_CLK2];
  assign wr_ctrl = wr & (addr == ADR_SER_CTRL);
  assign wr_buf = wr & (addr == ADR_SER_BUF);

  // Timer 1 in any of its running modes, fed by machine cycles or pin.
  always_comb begin
    logic step;
    step = t1_ctrl_q[T1C_RUN] &
           (timer_mode_reg_q[TM_T1_CNT_SEL] ? t1_fall : mc_tick);
    t1_low_d = t1_low_q;
    t1_reload_byte_d = t1_reload_byte_q;
    t1_ovf = 1'b0;
    if (step) begin
      case (timer_mode_reg_q[TM_T1_MODE_HI:TM_T1_MODE_LO])
        T1M_13BIT: begin
          t1_low_d = {3'h0, t1_low_q[4:0] + 5'h01};
          if (t1_low_q[4:0] == 5'h1F) begin
            t1_reload_byte_d = t1_reload_byte_q + 8'h01;
            t1_ovf = (t1_reload_byte_q == 8'hFF);
          end
        end
        T1M_16BIT: begin
          t1_low_d = t1_low_q + 8'h01;
          if (t1_low_q == 8'hFF) begin
            t1_reload_byte_d = t1_reload_byte_q + 8'h01;
            t1_ovf = (t1_reload_byte_q == 8'hFF);
          end
        end
        T1M_RELOAD: begin
          t1_low_d = (t1_low_q == 8'hFF) ? t1_reload_byte_q :
                     t1_low_q + 8'h01;
          t1_ovf = (t1_low_q == 8'hFF);
        end
        default: begin
          t1_low_d = t1_low_q;
        end
      endcase
    end
    if (wr && addr == ADR_T1_LOW) begin
      t1_low_d = wdata;
    end
    if (wr && addr == ADR_T1_RELOAD) begin
      t1_reload_byte_d = wdata;
    end
    t1_ctrl_d = t1_ctrl_q;
    if (wr && addr == ADR_T1_CTRL) begin
      t1_ctrl_d = wdata[1:0];
    end
    t1_ctrl_d[T1C_OVF] = t1_ctrl_d[T1C_OVF] | t1_ovf;
  end

  // Overflow dividers: timer 1 by 32 or 16, timer 2 by 16.
  always_comb begin
    t1_div_d = t1_div_q;
    t1_bit = 1'b0;
    if (t1_ovf) begin
      if (power_control_reg_q[PC_DOUBLE] ? (t1_div_q[3:0] == T1_DIV_DOUBLE)
                                         : (t1_div_q == T1_DIV_NORMAL)) begin
        t1_div_d = DIV_ZERO;
        t1_bit = 1'b1;
      end else begin
        t1_div_d = t1_div_q + 5'h01;
      end
    end
    t2_div_d = t2_ovf ? t2_div_q + 4'h1 : t2_div_q;
    t2_bit = t2_ovf & (t2_div_q == T2_DIV_END);
  end

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      t1_low_q <= RST_BYTE;
      t1_reload_byte_q <= RST_BYTE;
      t1_ctrl_q <= 2'h0;
      t1_div_q <= DIV_ZERO;
      t2_div_q <= 4'h0;
      p1_tx_bit_tick_q <= 1'b0;
      p1_rx_bit_tick_q <= 1'b0;
      p2_tx_bit_tick_q <= 1'b0;
      p2_rx_bit_tick_q <= 1'b0;
      t1_overflow_q <= 1'b0;
    end else begin
      t1_low_q <= t1_low_d;
      t1_reload_byte_q <= t1_reload_byte_d;
      t1_ctrl_q <= t1_ctrl_d;
      t1_div_q <= t1_div_d;
      t2_div_q <= t2_div_d;
      p1_tx_bit_tick_q <= mode_variable &
        (second_timer_control_reg_q[T2C_TX_CLK] ? t2_bit : t1_bit);
      p1_rx_bit_tick_q <= mode_variable &
        (second_timer_control_reg_q[T2C_RX_CLK] ? t2_bit : t1_bit);
      p2_tx_bit_tick_q <= power_control_reg_q[PC_TX_CLK2] ? t2_bit
                                                          : t1_bit;
      p2_rx_bit_tick_q <= power_control_reg_q[PC_RX_CLK2] ? t2_bit
                                                          : t1_bit;
      t1_overflow_q <= t1_ctrl_d[T1C_OVF];
    end
  end

  // Timer 2 counts and reload pair.
  ubg_timer2 u_timer2 (
    .mclk(mclk),
    .rstn(rstn),
    .state_tick(state_tick),
    .mc_tick(mc_tick),
    .run(second_timer_control_reg_q[T2C_RUN]),
    .counter_sel(second_timer_control_reg_q[T2C_CNT_SEL]),
    .baud_mode(t2_baud_mode),
    .ext_enable(second_timer_control_reg_q[T2C_EXT_EN]),
    .count_fall(t2_fall),
    .ext_fall(ext_fall),
    .wr_low(wr && addr == ADR_T2_LOW),
    .wr_high(wr && addr == ADR_T2_HIGH),
    .wr_rl_low(wr && addr == ADR_RL_LOW),
    .wr_rl_high(wr && addr == ADR_RL_HIGH),
    .wdata(wdata),
    .count_q(t2_count),
    .reload_q(t2_reload),
    .ovf_q(t2_ovf),
    .tf_set_q(t2_tf_set),
    .exf_set_q(t2_exf_set)
  );

  // Mode 0 transmit and receive sequencing on the machine phases.
  always_comb begin
    tx_st_d = tx_st_q;
    tx_sh_d = tx_sh_q;
    tx_done_set = 1'b0;
    case (tx_st_q)
      UBG_TX_IDLE: begin
        if (wr_buf && mode_zero) begin
          tx_sh_d = {TX_MARK, wdata};
          tx_st_d = UBG_TX_ARM;
        end
      end
      UBG_TX_ARM: begin
        if (mc_tick) begin
          tx_st_d = UBG_TX_SEND;
        end
      end
      UBG_TX_SEND: begin
        if (mc_tick) begin
          tx_sh_d = {1'b0, tx_sh_q[8:1]};
          if (tx_sh_q[8:1] == TX_LAST_PATTERN) begin
            tx_st_d = UBG_TX_LAST;
          end
        end
      end
      UBG_TX_LAST: begin
        if (phase_q == PH_S1P1) begin
          tx_st_d = UBG_TX_IDLE;
          tx_done_set = 1'b1;
        end
      end
      default: tx_st_d = UBG_TX_IDLE;
    endcase
    rx_st_d = rx_st_q;
    rx_sh_d = rx_sh_q;
    rx_done_set = 1'b0;
    serial_buffer_d = wr_buf ? wdata : serial_buffer_q;
    rx_sample_d = (phase_q == PH_S5P2) ? data_i : rx_sample_q;
    rx_word = {rx_sh_q[6:0], rx_sample_q};
    case (rx_st_q)
      UBG_RX_IDLE: begin
        if (mode_zero && serial_control_reg_q[SC_RX_EN] &&
            !serial_control_reg_q[SC_RX_DONE] &&
            tx_st_q == UBG_TX_IDLE) begin
          rx_st_d = UBG_RX_ARM;
        end
      end
      UBG_RX_ARM: begin
        if (mc_tick) begin
          rx_sh_d = RX_LOAD_PATTERN;
          rx_st_d = UBG_RX_ACT;
        end
      end
      UBG_RX_ACT: begin
        if (mc_tick) begin
          rx_sh_d = rx_word;
          if (!rx_sh_q[7]) begin
            serial_buffer_d = ubg_rev8(rx_word);
            rx_st_d = UBG_RX_LAST;
          end
        end
      end
      UBG_RX_LAST: begin
        if (phase_q == PH_S1P1) begin
          rx_st_d = UBG_RX_IDLE;
          rx_done_set = 1'b1;
        end
      end
      default: rx_st_d = UBG_RX_IDLE;
    endcase
  end

  // Shift clock is low from S3P1 through S5P2 while a transfer runs.
  assign clk_active = (tx_st_d == UBG_TX_SEND) || (tx_st_d == UBG_TX_LAST) ||
                      (rx_st_d == UBG_RX_ACT) || (rx_st_d == UBG_RX_LAST);

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      tx_st_q <= UBG_TX_IDLE;
      rx_st_q <= UBG_RX_IDLE;
      tx_sh_q <= 9'h000;
      rx_sh_q <= RST_BYTE;
      rx_sample_q <= 1'b0;
      serial_buffer_q <= RST_BYTE;
      data_o_q <= 1'b1;
      data_oe_n_q <= 1'b1;
      shift_clk_q <= 1'b1;
    end else begin
      tx_st_q <= tx_st_d;
      rx_st_q <= rx_st_d;
      tx_sh_q <= tx_sh_d;
      rx_sh_q <= rx_sh_d;
      rx_sample_q <= rx_sample_d;
      serial_buffer_q <= serial_buffer_d;
      data_o_q <= tx_sh_d[0];
      data_oe_n_q <= ~((tx_st_d == UBG_TX_SEND) ||
                       (tx_st_d == UBG_TX_LAST));
      shift_clk_q <= ~(clk_active && phase_d >= PH_S3P1 &&
                       phase_d <= PH_S5P2);
    end
  end

  // Control registers; a hardware set wins over a software clear.
  always_comb begin
    serial_control_reg_d = wr_ctrl ? wdata : serial_control_reg_q;
    serial_control_reg_d[SC_TX_DONE] = serial_control_reg_d[SC_TX_DONE] |
                                       tx_done_set;
    serial_control_reg_d[SC_RX_DONE] = serial_control_reg_d[SC_RX_DONE] |
                                       rx_done_set;
    timer_mode_reg_d = (wr && addr == ADR_TMODE) ? wdata : timer_mode_reg_q;
    power_control_reg_d = (wr && addr == ADR_PWR_CTRL) ? wdata
                                                       : power_control_reg_q;
    second_timer_control_reg_d = (wr && addr == ADR_T2_CTRL) ?
      {wdata[7:1], 1'b0} : second_timer_control_reg_q;
    second_timer_control_reg_d[T2C_OVF] =
      second_timer_control_reg_d[T2C_OVF] | t2_tf_set;
    second_timer_control_reg_d[T2C_EXT_FLAG] =
      second_timer_control_reg_d[T2C_EXT_FLAG] | t2_exf_set;
    case (addr)
      ADR_SER_CTRL: rdata_d = serial_control_reg_q;
      ADR_SER_BUF: rdata_d = serial_buffer_q;
      ADR_TMODE: rdata_d = timer_mode_reg_q;
      ADR_T1_LOW: rdata_d = t1_low_q;
      ADR_T1_RELOAD: rdata_d = t1_reload_byte_q;
      ADR_T1_CTRL: rdata_d = {6'h00, t1_ctrl_q};
      ADR_T2_CTRL: rdata_d = second_timer_control_reg_q;
      ADR_T2_LOW: rdata_d = t2_count[7:0];
      ADR_T2_HIGH: rdata_d = t2_count[15:8];
      ADR_RL_LOW: rdata_d = t2_reload[7:0];
      ADR_RL_HIGH: rdata_d = t2_reload[15:8];
      ADR_PWR_CTRL: rdata_d = power_control_reg_q;
      default: rdata_d = RST_BYTE;
    endcase
    if (!rd) begin
      rdata_d = RST_BYTE;
    end
  end

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      serial_control_reg_q <= RST_BYTE;
      timer_mode_reg_q <= RST_BYTE;
      power_control_reg_q <= RST_BYTE;
      second_timer_control_reg_q <= RST_BYTE;
      rdata_q <= RST_BYTE;
      tx_done_flag_q <= 1'b0;
      rx_done_flag_q <= 1'b0;
      t2_overflow_flag_q <= 1'b0;
      ext_trigger_flag_q <= 1'b0;
    end else begin
      serial_control_reg_q <= serial_control_reg_d;
      timer_mode_reg_q <= timer_mode_reg_d;
      power_control_reg_q <= power_control_reg_d;
      second_timer_control_reg_q <= second_timer_control_reg_d;
      rdata_q <= rdata_d;
      tx_done_flag_q <= serial_control_reg_d[SC_TX_DONE];
      rx_done_flag_q <= serial_control_reg_d[SC_RX_DONE];
      t2_overflow_flag_q <= second_timer_control_reg_d[T2C_OVF];
      ext_trigger_flag_q <= second_timer_control_reg_d[T2C_EXT_FLAG];
    end
  end

endmodule

/* ubg_properties.sv */
// Checker on the ports of the baud and shift port top.
// Assumes it is bound into ubg_top and sees only its ports.
module ubg_properties
  import ubg_pkg::*;
(
  input wire logic mclk,
  input wire logic rstn,
  input wire logic [3:0] addr,
  input wire logic wr,
  input wire logic data_o_q,
  input wire logic data_oe_n_q,
  input wire logic shift_clk_q,
  input wire logic p1_tx_bit_tick_q,
  input wire logic tx_done_flag_q,
  input wire logic rx_done_flag_q
);
  timeunit 1ns;
  timeprecision 1ns;
  // All checks run on the oscillator clock and rest during reset.
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!rstn);
  chk_clk_low_span: assert property (
    $fell(shift_clk_q) |-> !shift_clk_q [*6] ##1 shift_clk_q)
    else $error("shift clock low span wrong");
  chk_clk_high_span: assert property (
    $rose(shift_clk_q) |-> shift_clk_q [*6])
    else $error("shift clock high span wrong");
  chk_bit_hold: assert property (
    $changed(data_o_q) && !data_oe_n_q |=>
      ($stable(data_o_q) || data_oe_n_q) [*8])
    else $error("data bit held too short");
  chk_send_span: assert property (
    $fell(data_oe_n_q) |-> ##96 !data_oe_n_q ##1 data_oe_n_q)
    else $error("send window length wrong");
  chk_done_at_end: assert property (
    $rose(data_oe_n_q) |-> $rose(tx_done_flag_q))
    else $error("send ended without done flag");
  chk_rx_not_sending: assert property (
    $rose(rx_done_flag_q) |-> data_oe_n_q)
    else $error("receive ended while sending");
  chk_tx_flag_clear: assert property (
    $fell(tx_done_flag_q) |-> $past(wr) && $past(addr) == ADR_SER_CTRL)
    else $error("send flag cleared by hardware");
  chk_tick_pulse: assert property (
    p1_tx_bit_tick_q |=> !p1_tx_bit_tick_q [*8])
    else $error("bit tick too long");
endmodule

/* ubg_shift_peer.sv */
// Far-side shift device for the mode 0 port.
// Assumes it sees the resolved data pin and the port's shift clock.
module ubg_shift_peer (
  input wire logic shift_clk,
  input wire logic pin,
  input wire logic port_drives,
  input wire logic [7:0] load_byte,
  input wire logic load,
  output logic drive_bit,
  output logic [7:0] got_byte,
  output int rises
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [7:0] out_q;
  // Line idles at the pull-up level until a byte is offered.
  initial begin
    drive_bit = 1'b1;
    out_q = 8'hFF;
    got_byte = 8'h00;
    rises = 0;
  end
  // Takes a new byte to offer and clears the count of taken bits.
  always @(posedge load) begin
    out_q = load_byte;
    rises = 0;
  end
  // Next bit goes out as the clock falls, LSB first.
  always @(negedge shift_clk) begin
    if (!port_drives) begin
      drive_bit = out_q[0];
      out_q = {1'b1, out_q[7:1]};
    end
  end
  // Port bits are taken on each rise; else the pull-up wins.
  always @(posedge shift_clk) begin
    if (port_drives) begin
      got_byte = {pin, got_byte[7:1]};
      rises = rises + 1;
    end else begin
      drive_bit = 1'b1;
    end
  end
endmodule

/* uart_baud_gen_shift_mode_tb.sv */
// Bench for the baud generator and mode 0 shift port.
// Assumes package, design, checker and shift peer are compiled first.
module uart_baud_gen_shift_mode_tb
  import ubg_pkg::*;
  ;
  timeunit 1ns;
  timeprecision 1ns;
  logic mclk = 1'b0, rstn = 1'b0, wr = 1'b0, rd = 1'b0, ld = 1'b0;
  logic t1_pin = 1'b1, ext_pin = 1'b1, oe_n, sclk, d_o, pk, pin, txd, rxd;
  logic [3:0] addr = 4'h0, tk;
  logic [7:0] wdata = 8'h00, rdata, pb = 8'h96, sent, got;
  logic [15:0] g;
  logic [2:0] fl;
  int failures = 0, checks_done = 0, rises;
  // Data pin level from whichever side drives it.
  assign pin = oe_n ? pk : d_o;
  ubg_top DUT (.mclk(mclk), .rstn(rstn), .addr(addr), .wdata(wdata),
    .wr(wr), .rd(rd), .rdata_q(rdata), .data_i(pin), .data_o_q(d_o),
    .data_oe_n_q(oe_n), .shift_clk_q(sclk), .t1_count_pin(t1_pin),
    .t2_count_pin(t1_pin), .ext_trigger_pin(ext_pin),
    .p1_tx_bit_tick_q(tk[0]), .p1_rx_bit_tick_q(tk[1]),
    .p2_tx_bit_tick_q(tk[2]), .p2_rx_bit_tick_q(tk[3]),
    .tx_done_flag_q(txd), .rx_done_flag_q(rxd), .t1_overflow_q(fl[0]),
    .t2_overflow_flag_q(fl[1]), .ext_trigger_flag_q(fl[2]));
  ubg_shift_peer peer (.shift_clk(sclk), .pin(pin), .port_drives(!oe_n),
    .load_byte(pb), .load(ld), .drive_bit(pk), .got_byte(sent),
    .rises(rises));
  // Oscillator, and a count pin that falls every two machine cycles.
  always #50 mclk = ~mclk;
  always begin
    repeat (12) @(posedge mclk);
    t1_pin <= ~t1_pin;
  end
  // Bus cycles, settled sampling and comparison.
  task automatic step();
    @(posedge mclk);
    #1;
  endtask
  task automatic wreg(input logic [3:0] a, input logic [7:0] d);
    @(posedge mclk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge mclk);
    wr <= 1'b0;
  endtask
  task automatic rreg(input logic [3:0] a);
    @(posedge mclk);
    addr <= a;
    rd <= 1'b1;
    @(posedge mclk);
    rd <= 1'b0;
    #1 got = rdata;
  endtask
  task automatic check(input logic [15:0] s, input logic [15:0] e);
    checks_done++;
    if (s !== e) begin
      failures++;
      $display("wrong value at %0t: saw %h want %h", $time, s, e);
    end
  endtask
  // Cycles between the last two of three ticks on one line.
  task automatic gap(input int i);
    int n;
    n = 0;
    repeat (3) begin
      g = 16'h0000;
      step();
      while (tk[i] !== 1'b1 && n < 9000) begin
        step();
        g++;
        n++;
      end
    end
    g++;
  endtask
  task automatic test_done();
    $display("checks %0d failures %0d", checks_done, failures);
    if (failures == 0 && checks_done > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  // Register read straight after reset.
  task automatic t_reset();
    rreg(ADR_SER_CTRL);
    check(16'(got), 16'h0000);
    $display("reset test ended");
  endtask
  // Mode 0 send of one byte, then the flag cleared by software.
  task automatic t_send();
    int n;
    n = 0;
    wreg(ADR_SER_BUF, 8'hA5);
    while (oe_n !== 1'b0 && n < 20) begin
      step();
      n++;
    end
    check(16'(n > 0 && n < 13), 16'h0001);
    while (txd !== 1'b1 && n < 200) begin
      step();
      n++;
    end
    check(16'(sent), 16'h00A5);
    check(16'(rises), 16'h0008);
    rreg(ADR_SER_CTRL);
    check(16'(got), 16'h0002);
    wreg(ADR_SER_CTRL, 8'h00);
    $display("send test ended");
  endtask
  // Mode 0 receive, then no new receive while the flag is set.
  task automatic t_recv();
    int n;
    n = 0;
    @(posedge mclk);
    ld <= 1'b1;
    @(posedge mclk);
    ld <= 1'b0;
    wreg(ADR_SER_CTRL, 8'h10);
    while (rxd !== 1'b1 && n < 200) begin
      step();
      n++;
    end
    check(16'(n > 96 && n < 123), 16'h0001);
    rreg(ADR_SER_BUF);
    check(16'(got), 16'h0096);
    n = 0;
    repeat (30) begin
      step();
      n = n + sclk;
    end
    check(16'(n), 16'h001E);
    wreg(ADR_SER_CTRL, 8'h00);
    for (int m = 1; m < 4; m++) begin
      wreg(ADR_SER_CTRL, {m[1:0], 6'h00});
      wreg(ADR_SER_BUF, 8'h5A);
      n = 0;
      repeat (24) begin
        step();
        n = n + oe_n;
      end
      check(16'(n), 16'h0018);
    end
    $display("receive and mode test ended");
  endtask
  // One timer 1 setting and the bit time it should give.
  task automatic t1_run(input logic [7:0] m, r, p, input logic [15:0] e);
    wreg(ADR_TMODE, m);
    wreg(ADR_T1_RELOAD, r);
    wreg(ADR_PWR_CTRL, p);
    gap(0);
    check(g, e);
  endtask
  // Timer 2 overflow interrupt stays off while it clocks the port.
  task automatic t_timers();
    wreg(ADR_SER_CTRL, 8'h40);
    wreg(ADR_T1_LOW, 8'hFF);
    wreg(ADR_T1_CTRL, 8'h01);
    t1_run(8'h20, 8'hFF, 8'h00, 16'h0180);
    t1_run(8'h20, 8'hFF, 8'h80, 16'h00C0);
    t1_run(8'h20, 8'hFE, 8'h80, 16'h0180);
    t1_run(8'h60, 8'hFF, 8'h00, 16'h0300);
    wreg(ADR_T2_CTRL, 8'h00);
    wreg(ADR_RL_LOW, 8'hF0);
    wreg(ADR_RL_HIGH, 8'hFF);
    wreg(ADR_T2_LOW, 8'hF0);
    wreg(ADR_T2_HIGH, 8'hFF);
    wreg(ADR_PWR_CTRL, 8'h20);
    wreg(ADR_T2_CTRL, 8'h1C);
    gap(0);
    check(g, 16'h0200);
    gap(3);
    check(g, 16'h0200);
    gap(1);
    check(g, 16'h0300);
    wreg(ADR_T1_CTRL, 8'h00);
    wreg(ADR_TMODE, 8'h10);
    wreg(ADR_T1_LOW, 8'hF8);
    wreg(ADR_T1_RELOAD, 8'hFF);
    wreg(ADR_T1_CTRL, 8'h01);
    step();
    check(16'(fl[0]), 16'h0000);
    repeat (120) step();
    check(16'(fl[0]), 16'h0001);
    @(posedge mclk);
    ext_pin <= 1'b0;
    repeat (30) step();
    rreg(ADR_T2_CTRL);
    check(16'(got), 16'h005C);
    check(16'(fl), 16'h0005);
    gap(0);
    check(g, 16'h0200);
    $display("timer test ended");
  endtask
  // Reset, then each test in turn.
  initial begin
    repeat (4) @(posedge mclk);
    rstn <= 1'b1;
    t_reset();
    t_send();
    t_recv();
    t_timers();
    test_done();
  end
  // Watchdog cuts a hang short.
  initial begin
    #4000000;
    failures++;
    test_done();
  end
endmodule
bind ubg_top ubg_properties chk (.mclk(mclk), .rstn(rstn), .addr(addr),
  .wr(wr), .data_o_q(data_o_q), .data_oe_n_q(data_oe_n_q),
  .shift_clk_q(shift_clk_q), .p1_tx_bit_tick_q(p1_tx_bit_tick_q),
  .tx_done_flag_q(tx_done_flag_q), .rx_done_flag_q(rx_done_flag_q));
